// >>> verilog/rxf_defs.svh
`ifndef RXF_DEFS_SVH
`define RXF_DEFS_SVH

// Channel count and register port widths
`define RXF_NUM_CHAN   4
`define RXF_CHAN_W     2
`define RXF_IDX_W      3
`define RXF_REG_W      5

// Register indices on the command port
`define RXF_CR3_IDX    3'h3
`define RXF_CR4_IDX    3'h4

// Reset values and writable bits
`define RXF_CR3_RESET  5'h00
`define RXF_CR4_RESET  5'h00
`define RXF_CR3_MASK   5'h1E
`define RXF_CR4_MASK   5'h0F

// Receive output config field positions
`define RXF_CR3_RAIL   4
`define RXF_CR3_MUTE   3
`define RXF_CR3_OFF    2
`define RXF_CR3_INV    1

// Rate and loop config field positions
`define RXF_CR4_STS    3
`define RXF_CR4_EURO   2
`define RXF_CR4_LLB    1
`define RXF_CR4_RLB    0

// Global pins plus two loop pins per channel
`define RXF_PIN_W      12

`endif

// >>> verilog/rxf_pkg.sv
`include "rxf_defs.svh"

package rxf_pkg;

  // Loop-back selection, one-hot
  typedef enum logic [3:0] {
    RXF_LOOP_NONE    = 4'h1,
    RXF_LOOP_ANALOG  = 4'h2,
    RXF_LOOP_DIGITAL = 4'h4,
    RXF_LOOP_REMOTE  = 4'h8
  } rxf_loop_t;

  typedef logic [`RXF_REG_W-1:0] rxf_word_t;

  // Resolved per-channel receive configuration
  typedef struct packed {
    logic      clk_inv;
    logic      single_rail;
    logic      rx_off;
    rxf_loop_t loop;
  } rxf_chcfg_t;

  // Whole state of the top module
  typedef struct packed {
    rxf_word_t  [`RXF_NUM_CHAN-1:0] cr3;
    rxf_word_t  [`RXF_NUM_CHAN-1:0] cr4;
    rxf_word_t                      rdata;
    logic                           rvalid;
    rxf_chcfg_t [`RXF_NUM_CHAN-1:0] cfg;
  } rxf_top_st_t;

  // Whole state of one link-side lane
  typedef struct packed {
    logic tx_pos;
    logic tx_neg;
    logic rx_pos;
    logic rx_neg;
  } rxf_lane_st_t;

  // Local and remote loop controls to loop mode
  function automatic rxf_loop_t rxf_loop_decode(input logic llb, input logic rlb);
    rxf_loop_t m;
    unique case ({llb, rlb})
      2'h0: m = RXF_LOOP_NONE;
      2'h1: m = RXF_LOOP_REMOTE;
      2'h2: m = RXF_LOOP_ANALOG;
      2'h3: m = RXF_LOOP_DIGITAL;
    endcase
    return m;
  endfunction

endpackage

// >>> verilog/rxf_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none

// Configuration handed from the system domain to one lane
interface rxf_cfg_if;
  import rxf_pkg::*;
  rxf_chcfg_t cfg;
  logic       ce;
  modport src (output cfg, output ce);
  modport dst (input cfg, input ce);
endinterface

`default_nettype wire

// >>> verilog/rxf_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rxf_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } rxf_sync_st_t;

  rxf_sync_st_t st_reg, st_next;

  // Two stages; only the second stage reads the first
  always_comb begin
    st_next = st_reg;
    if (en_i) begin
      st_next.meta = d_i;
      st_next.hold = st_reg.meta;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.hold;

endmodule // rxf_sync

`default_nettype wire

// >>> verilog/rxf_lane.sv
`timescale 1ns/100ps
`default_nettype none

module rxf_lane (
  // Link clock and reset
  input  wire logic link_clk_i,
  input  wire logic rst_i,
  // Configuration from system domain
  rxf_cfg_if.dst    cfg_if,
  // Line receive and encoded transmit data
  input  wire logic line_pos_i,
  input  wire logic line_neg_i,
  input  wire logic enc_pos_i,
  input  wire logic enc_neg_i,
  // Terminal and line outputs
  output logic      rx_pos_o,
  output logic      rx_neg_o,
  output logic      rx_clk_o,
  output logic      line_tx_pos_o,
  output logic      line_tx_neg_o
);
  import rxf_pkg::*;

  logic [7:0]   cfg_q;
  rxf_chcfg_t   cfg;
  logic         ce_l;
  logic         src_pos;
  logic         src_neg;
  rxf_lane_st_t st_reg, st_next;

  // Quasi-static settings, each bit through two flops
  rxf_sync #(.W(8)) u_cfg_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .en_i  (1'b1),
    .d_i   ({cfg_if.ce, cfg_if.cfg}),
    .q_o   (cfg_q)
  );
  assign ce_l = cfg_q[7];
  assign cfg  = rxf_chcfg_t'(cfg_q[6:0]);

  // Receive source and output format
  always_comb begin
    st_next = st_reg;
    src_pos = line_pos_i;
    src_neg = line_neg_i;
    unique case (cfg.loop)
      RXF_LOOP_ANALOG: begin
        src_pos = st_reg.tx_pos;
        src_neg = st_reg.tx_neg;
      end
      RXF_LOOP_DIGITAL: begin
        src_pos = enc_pos_i;
        src_neg = enc_neg_i;
      end
      RXF_LOOP_NONE, RXF_LOOP_REMOTE: begin
        src_pos = line_pos_i;
        src_neg = line_neg_i;
      end
      default: begin
        src_pos = line_pos_i;
        src_neg = line_neg_i;
      end
    endcase
    if (ce_l) begin
      st_next.tx_pos = enc_pos_i;
      st_next.tx_neg = enc_neg_i;
      if (cfg.rx_off) begin
        st_next.rx_pos = 1'b0;
        st_next.rx_neg = 1'b0;
      end else if (cfg.single_rail) begin
        st_next.rx_pos = src_pos | src_neg;
        st_next.rx_neg = 1'b0;
      end else begin
        st_next.rx_pos = src_pos;
        st_next.rx_neg = src_neg;
      end
    end
  end

  // data launched on rising link edge
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // inverted clock puts launch on its falling edge
  assign rx_clk_o      = ~cfg.rx_off & (link_clk_i ^ cfg.clk_inv);
  assign rx_pos_o      = st_reg.rx_pos;
  assign rx_neg_o      = st_reg.rx_neg;
  assign line_tx_pos_o = st_reg.tx_pos;
  assign line_tx_neg_o = st_reg.tx_neg;

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_live_dual;
    ce_l && !cfg.rx_off && !cfg.single_rail;
  endsequence

  a_single_neg_low: assert property (
    ce_l && cfg.single_rail |=> !rx_neg_o)
    else $error("negative rail active in single-rail mode");
  a_single_pos_data: assert property (
    ce_l && !cfg.rx_off && cfg.single_rail |=> rx_pos_o == $past(src_pos | src_neg))
    else $error("single-rail data wrong");
  a_digital_loop_data: assert property (
    s_live_dual and (cfg.loop == RXF_LOOP_DIGITAL) |=> rx_pos_o == $past(enc_pos_i))
    else $error("digital loop data wrong");
  a_analog_loop_data: assert property (
    (s_live_dual and (cfg.loop == RXF_LOOP_ANALOG)) ##1
    (s_live_dual and (cfg.loop == RXF_LOOP_ANALOG))
    |=> rx_neg_o == $past(enc_neg_i, 2) && line_tx_neg_o == $past(enc_neg_i))
    else $error("analog loop data wrong");
  a_normal_dual_data: assert property (
    s_live_dual and (cfg.loop == RXF_LOOP_NONE)
    |=> rx_pos_o == $past(line_pos_i) && rx_neg_o == $past(line_neg_i))
    else $error("dual-rail data does not follow line");

endmodule // rxf_lane

`default_nettype wire

// >>> verilog/rxf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rxf_defs.svh"

module rxf_top (
  // Clock, reset and enable
  input  wire logic                     REF_CLK_I,
  input  wire logic                     SYS_RST_I,
  input  wire logic                     CE_I,
  // Global hardware-mode pins
  input  wire logic                     HOST_MODE_I,
  input  wire logic                     RX_CLK_INV_PIN_I,
  input  wire logic                     RAIL_FMT_SEL_I,
  input  wire logic                     RX_SHUTOFF_I,
  // Per-channel loop pins
  input  wire logic [`RXF_NUM_CHAN-1:0] LOCAL_LOOP_SEL_I,
  input  wire logic [`RXF_NUM_CHAN-1:0] REMOTE_LOOP_SEL_I,
  // Command register port
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  input  wire logic [`RXF_CHAN_W-1:0]   REG_CHAN_I,
  input  wire logic [`RXF_IDX_W-1:0]    REG_IDX_I,
  input  wire logic [`RXF_REG_W-1:0]    REG_WDATA_I,
  output logic      [`RXF_REG_W-1:0]    REG_RDATA_O,
  output logic                          REG_RVALID_O,
  // Link side, one bit per channel
  input  wire logic [`RXF_NUM_CHAN-1:0] LINK_CLK_I,
  input  wire logic [`RXF_NUM_CHAN-1:0] LINE_RX_PLUS_I,
  input  wire logic [`RXF_NUM_CHAN-1:0] LINE_RX_MINUS_I,
  input  wire logic [`RXF_NUM_CHAN-1:0] TX_POS_DATA_I,
  input  wire logic [`RXF_NUM_CHAN-1:0] TX_NEG_DATA_I,
  output logic      [`RXF_NUM_CHAN-1:0] LINE_TX_PLUS_O,
  output logic      [`RXF_NUM_CHAN-1:0] LINE_TX_MINUS_O,
  // Receiving terminal side
  output logic      [`RXF_NUM_CHAN-1:0] RX_POS_RAIL_O,
  output logic      [`RXF_NUM_CHAN-1:0] RX_NEG_RAIL_O,
  output logic      [`RXF_NUM_CHAN-1:0] REC_CLK_O
);
  import rxf_pkg::*;

  // Synchronised pins
  logic [`RXF_PIN_W-1:0]    pin_q;
  logic                     host_s;
  logic                     inv_s;
  logic                     rail_s;
  logic                     off_s;
  logic [`RXF_NUM_CHAN-1:0] llb_s;
  logic [`RXF_NUM_CHAN-1:0] rlb_s;

  rxf_top_st_t st_reg, st_next;

  // Mode pins come from outside, two flops first
  rxf_sync #(.W(`RXF_PIN_W)) u_pin_sync (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .en_i  (CE_I),
    .d_i   ({HOST_MODE_I, RX_CLK_INV_PIN_I, RAIL_FMT_SEL_I, RX_SHUTOFF_I,
             LOCAL_LOOP_SEL_I, REMOTE_LOOP_SEL_I}),
    .q_o   (pin_q)
  );

  // Field split of the synchronised pins
  assign host_s = pin_q[11];
  assign inv_s  = pin_q[10];
  assign rail_s = pin_q[9];
  assign off_s  = pin_q[8];
  assign llb_s  = pin_q[7:4];
  assign rlb_s  = pin_q[3:0];

  // Read mux; reserved bits were masked at write time
  function automatic rxf_word_t reg_read(input rxf_word_t cr3, input rxf_word_t cr4,
                                         input logic [`RXF_IDX_W-1:0] idx);
    rxf_word_t v;
    v = 5'h00;
    if (idx == `RXF_CR3_IDX) begin
      v = cr3;
    end else if (idx == `RXF_CR4_IDX) begin
      v = cr4;
    end
    return v;
  endfunction

  // Host bits or global and per-channel loop pins to one channel setting
  function automatic rxf_chcfg_t resolve(input logic host, input rxf_word_t cr3,
                                         input rxf_word_t cr4, input logic llb,
                                         input logic rlb);
    rxf_chcfg_t c;
    if (host) begin
      c.clk_inv     = cr3[`RXF_CR3_INV];
      c.single_rail = cr3[`RXF_CR3_RAIL];
      c.rx_off      = cr3[`RXF_CR3_OFF];
      c.loop        = rxf_loop_decode(cr4[`RXF_CR4_LLB], cr4[`RXF_CR4_RLB]);
    end else begin
      c.clk_inv     = inv_s;
      c.single_rail = rail_s;
      c.rx_off      = off_s;
      c.loop        = rxf_loop_decode(llb, rlb);
    end
    return c;
  endfunction

  // Register writes, reads and configuration resolve
  always_comb begin
    st_next = st_reg;
    if (CE_I) begin
      st_next.rvalid = 1'b0;
      if (REG_WR_I && REG_IDX_I == `RXF_CR3_IDX) begin
        st_next.cr3[REG_CHAN_I] = REG_WDATA_I & `RXF_CR3_MASK;
      end
      if (REG_WR_I && REG_IDX_I == `RXF_CR4_IDX) begin
        st_next.cr4[REG_CHAN_I] = REG_WDATA_I & `RXF_CR4_MASK;
      end
      if (REG_RD_I) begin
        st_next.rdata  = reg_read(st_reg.cr3[REG_CHAN_I], st_reg.cr4[REG_CHAN_I],
                                  REG_IDX_I);
        st_next.rvalid = 1'b1;
      end
      // each channel resolved on its own
      for (int c = 0; c < `RXF_NUM_CHAN; c++) begin
        st_next.cfg[c] = resolve(host_s, st_reg.cr3[c], st_reg.cr4[c],
                                 llb_s[c], rlb_s[c]);
      end
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_reg       <= '0;
      st_reg.cr3   <= {`RXF_NUM_CHAN{`RXF_CR3_RESET}};
      st_reg.cr4   <= {`RXF_NUM_CHAN{`RXF_CR4_RESET}};
      for (int c = 0; c < `RXF_NUM_CHAN; c++) begin
        st_reg.cfg[c].loop <= RXF_LOOP_NONE;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA_O  = st_reg.rdata;
  assign REG_RVALID_O = st_reg.rvalid;

  // One lane per channel, each on its own recovered clock
  for (genvar g = 0; g < `RXF_NUM_CHAN; g++) begin : g_chan
    rxf_cfg_if u_cfg ();
    // Settings are quasi-static; the lane synchronises each bit
    assign u_cfg.cfg = st_reg.cfg[g];
    assign u_cfg.ce  = CE_I;

    rxf_lane u_lane (
      .link_clk_i    (LINK_CLK_I[g]),
      .rst_i         (SYS_RST_I),
      .cfg_if        (u_cfg),
      .line_pos_i    (LINE_RX_PLUS_I[g]),
      .line_neg_i    (LINE_RX_MINUS_I[g]),
      .enc_pos_i     (TX_POS_DATA_I[g]),
      .enc_neg_i     (TX_NEG_DATA_I[g]),
      .rx_pos_o      (RX_POS_RAIL_O[g]),
      .rx_neg_o      (RX_NEG_RAIL_O[g]),
      .rx_clk_o      (REC_CLK_O[g]),
      .line_tx_pos_o (LINE_TX_PLUS_O[g]),
      .line_tx_neg_o (LINE_TX_MINUS_O[g])
    );
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Per-channel checks on the registers and the resolved configuration
  for (genvar g = 0; g < `RXF_NUM_CHAN; g++) begin : g_chk

    // Host write to one register of this channel, then held in host mode
    sequence s_cr3_wr;
      CE_I && host_s && REG_WR_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR3_IDX;
    endsequence
    sequence s_cr4_wr;
      CE_I && host_s && REG_WR_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR4_IDX;
    endsequence
    sequence s_host_hold;
      CE_I && host_s && !(REG_WR_I && REG_CHAN_I == g);
    endsequence
    sequence s_hw;
      CE_I && !host_s;
    endsequence
    sequence s_host_live;
      CE_I && host_s;
    endsequence

    a_hw_inv_high: assert property (
      s_hw ##0 inv_s |=> st_reg.cfg[g].clk_inv)
      else $error("hardware invert pin high not applied");

    a_hw_inv_low: assert property (
      s_hw ##0 !inv_s |=> !st_reg.cfg[g].clk_inv)
      else $error("hardware invert pin low not applied");

    a_host_inv_bit: assert property (
      s_cr3_wr ##1 s_host_hold
      |=> st_reg.cfg[g].clk_inv == $past(REG_WDATA_I[`RXF_CR3_INV], 2))
      else $error("host invert bit not applied");

    a_host_rail_bit: assert property (
      s_cr3_wr ##1 s_host_hold
      |=> st_reg.cfg[g].single_rail == $past(REG_WDATA_I[`RXF_CR3_RAIL], 2))
      else $error("host rail bit not applied");

    a_hw_rail_pin: assert property (
      s_hw |=> st_reg.cfg[g].single_rail == $past(rail_s))
      else $error("rail-select pin not applied");

    a_hw_shutoff_pin: assert property (
      s_hw |=> st_reg.cfg[g].rx_off == $past(off_s))
      else $error("shutoff pin not applied");

    a_host_shutoff_bit: assert property (
      s_cr3_wr ##1 s_host_hold
      |=> st_reg.cfg[g].rx_off == $past(REG_WDATA_I[`RXF_CR3_OFF], 2))
      else $error("host shutoff bit not applied");

    a_host_analog_loop: assert property (
      (s_cr4_wr ##0 REG_WDATA_I[1:0] == 2'h2) ##1 s_host_hold
      |=> st_reg.cfg[g].loop == RXF_LOOP_ANALOG)
      else $error("host analog loop not entered");

    a_hw_analog_loop: assert property (
      s_hw ##0 llb_s[g] && !rlb_s[g] |=> st_reg.cfg[g].loop == RXF_LOOP_ANALOG)
      else $error("pin analog loop not entered");

    a_host_digital_loop: assert property (
      (s_cr4_wr ##0 REG_WDATA_I[1:0] == 2'h3) ##1 s_host_hold
      |=> st_reg.cfg[g].loop == RXF_LOOP_DIGITAL)
      else $error("host digital loop not entered");

    a_hw_digital_loop: assert property (
      s_hw ##0 llb_s[g] && rlb_s[g] |=> st_reg.cfg[g].loop == RXF_LOOP_DIGITAL)
      else $error("pin digital loop not entered");

    a_no_loop_normal: assert property (
      s_hw ##0 !llb_s[g] && !rlb_s[g] |=> st_reg.cfg[g].loop == RXF_LOOP_NONE)
      else $error("loop active with both controls low");

    a_chan_isolated: assert property (
      REG_WR_I && REG_CHAN_I != g
      |=> $stable(st_reg.cr3[g]) && $stable(st_reg.cr4[g]))
      else $error("write reached another channel");

    a_cr3_readback: assert property (
      s_cr3_wr ##1 (CE_I && !REG_WR_I)
      ##1 (CE_I && REG_RD_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR3_IDX && !REG_WR_I)
      |=> REG_RVALID_O && REG_RDATA_O == ($past(REG_WDATA_I, 3) & `RXF_CR3_MASK))
      else $error("receive config read-back wrong");

    a_cr4_readback: assert property (
      s_cr4_wr ##1 (CE_I && !REG_WR_I)
      ##1 (CE_I && REG_RD_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR4_IDX && !REG_WR_I)
      |=> REG_RVALID_O && REG_RDATA_O == ($past(REG_WDATA_I, 3) & `RXF_CR4_MASK))
      else $error("rate and loop config read-back wrong");

    // A write lands in its own channel at once, in either mode
    a_cr3_write_lands: assert property (
      CE_I && REG_WR_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR3_IDX
      |=> st_reg.cr3[g] == ($past(REG_WDATA_I) & `RXF_CR3_MASK))
      else $error("receive config write lost");

    a_cr4_write_lands: assert property (
      CE_I && REG_WR_I && REG_CHAN_I == g && REG_IDX_I == `RXF_CR4_IDX
      |=> st_reg.cr4[g] == ($past(REG_WDATA_I) & `RXF_CR4_MASK))
      else $error("rate and loop config write lost");

    // Host mode follows the stored bits, whatever the pins say
    a_host_inv_track: assert property (
      s_host_live |=> st_reg.cfg[g].clk_inv == $past(st_reg.cr3[g][`RXF_CR3_INV]))
      else $error("host invert bit not followed");

    a_host_rail_track: assert property (
      s_host_live |=> st_reg.cfg[g].single_rail == $past(st_reg.cr3[g][`RXF_CR3_RAIL]))
      else $error("host rail bit not followed");

    a_host_off_track: assert property (
      s_host_live |=> st_reg.cfg[g].rx_off == $past(st_reg.cr3[g][`RXF_CR3_OFF]))
      else $error("host shutoff bit not followed");

    a_host_analog_track: assert property (
      s_host_live ##0 st_reg.cr4[g][1:0] == 2'h2 |=> st_reg.cfg[g].loop == RXF_LOOP_ANALOG)
      else $error("host analog loop bits not followed");

    a_host_digital_track: assert property (
      s_host_live ##0 st_reg.cr4[g][1:0] == 2'h3 |=> st_reg.cfg[g].loop == RXF_LOOP_DIGITAL)
      else $error("host digital loop bits not followed");

    a_host_no_loop: assert property (
      s_host_live ##0 st_reg.cr4[g][1:0] == 2'h0 |=> st_reg.cfg[g].loop == RXF_LOOP_NONE)
      else $error("loop active with both host bits clear");
  end

  // Read answer is a single-cycle strobe
  a_rvalid_pulse: assert property (
    CE_I && !REG_RD_I |=> !REG_RVALID_O)
    else $error("read strobe without a read");

  // Every accepted read answers on the next edge
  a_rvalid_answer: assert property (
    CE_I && REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered");

  // Read data stands until the next read
  a_rdata_holds: assert property (
    !(CE_I && REG_RD_I) |=> $stable(REG_RDATA_O))
    else $error("read data changed without a read");

  // Unmapped indices read as zero
  a_unmapped_zero: assert property (
    CE_I && REG_RD_I && REG_IDX_I != `RXF_CR3_IDX && REG_IDX_I != `RXF_CR4_IDX
    |=> REG_RDATA_O == 5'h00)
    else $error("unmapped index read not zero");

  // Enable low freezes every system-domain register
  a_ce_freeze: assert property (
    !CE_I |=> $stable(st_reg))
    else $error("state moved with enable low");

endmodule // rxf_top

`default_nettype wire

// >>> sim/rxf_term_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "rxf_defs.svh"

// Far-end line source and transmitting framer for all four channels
module rxf_term_model (
  // Recovered clock toward the lanes
  output logic                               link_clk_o,
  // Line pulses and encoded transmit rails, one bit per channel
  output logic [`RXF_NUM_CHAN-1:0]           line_p_o,
  output logic [`RXF_NUM_CHAN-1:0]           line_n_o,
  output logic [`RXF_NUM_CHAN-1:0]           tx_p_o,
  output logic [`RXF_NUM_CHAN-1:0]           tx_n_o,
  // Last three launched words, newest in slot 0
  output logic [2:0][4*`RXF_NUM_CHAN-1:0]    hist_o
);
  logic [15:0] lfsr = 16'hACE1;

  // Free-running recovered clock, offset from the system clock
  initial begin
    link_clk_o = 1'b0;
    #1.3;
    forever #62.5 link_clk_o = ~link_clk_o;
  end

  // New bit per link cycle, launched just after the rising edge
  always @(posedge link_clk_o) begin
    #1;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    // Never a positive and a negative pulse in the same bit
    hist_o = {hist_o[1:0], lfsr & ~({lfsr[14:0], 1'b0} & 16'hAAAA)};
  end

  // Present the newest word on the pins
  always_comb begin
    for (int c = 0; c < `RXF_NUM_CHAN; c++) begin
      line_p_o[c] = hist_o[0][4*c];
      line_n_o[c] = hist_o[0][4*c+1];
      tx_p_o[c]   = hist_o[0][4*c+2];
      tx_n_o[c]   = hist_o[0][4*c+3];
    end
  end
endmodule // rxf_term_model

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rxf_defs.svh"

module testbench;
  import rxf_pkg::*;
  // System side stimulus
  logic             ref_clk;
  logic             rst;
  logic             ce;
  logic             host;
  logic             inv_pin;
  logic             rail_pin;
  logic             off_pin;
  logic [3:0]       ll_pin;
  logic [3:0]       rl_pin;
  logic             wr;
  logic             rd;
  logic [1:0]       chan;
  logic [2:0]       idx;
  rxf_word_t        wdata;
  rxf_word_t        rdata;
  logic             rvalid;
  // Link side
  logic             lk;
  logic [3:0]       lp, ln, tp, tn, ltp, ltn, rp, rn, rc;
  logic [2:0][15:0] hist;
  // Expected channel setup
  logic [3:0]       e_inv, e_sr, e_off;
  int               e_lp [4];
  int               fails, n_compared;

  rxf_top DUT (
    .REF_CLK_I(ref_clk), .SYS_RST_I(rst), .CE_I(ce), .HOST_MODE_I(host),
    .RX_CLK_INV_PIN_I(inv_pin), .RAIL_FMT_SEL_I(rail_pin), .RX_SHUTOFF_I(off_pin),
    .LOCAL_LOOP_SEL_I(ll_pin), .REMOTE_LOOP_SEL_I(rl_pin), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_CHAN_I(chan), .REG_IDX_I(idx), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .LINK_CLK_I({4{lk}}), .LINE_RX_PLUS_I(lp), .LINE_RX_MINUS_I(ln),
    .TX_POS_DATA_I(tp), .TX_NEG_DATA_I(tn), .LINE_TX_PLUS_O(ltp), .LINE_TX_MINUS_O(ltn),
    .RX_POS_RAIL_O(rp), .RX_NEG_RAIL_O(rn), .REC_CLK_O(rc)
  );

  rxf_term_model far_end (
    .link_clk_o(lk), .line_p_o(lp), .line_n_o(ln), .tx_p_o(tp), .tx_n_o(tn), .hist_o(hist)
  );

  // System clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // Count and report one comparison
  task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register write on the command port
  task automatic reg_wr(input int c, input logic [2:0] i, input rxf_word_t d);
    @(posedge ref_clk);
    #1;
    wr = 1'b1;
    chan = 2'(c);
    idx = i;
    wdata = d;
    @(posedge ref_clk);
    #1;
    wr = 1'b0;
  endtask

  // One register read, waiting a bounded time for the valid pulse
  task automatic reg_rd(input int c, input logic [2:0] i, input rxf_word_t exp);
    @(posedge ref_clk);
    #1;
    rd = 1'b1;
    chan = 2'(c);
    idx = i;
    @(posedge ref_clk);
    #1;
    rd = 1'b0;
    for (int k = 0; k < 3 && rvalid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    cmp({rvalid, rdata}, {1'b1, exp});
  endtask

  // Let settings land, then sample rails mid-low of the link clock
  task automatic check_rails(input int n);
    logic [15:0] src;
    int          sh;
    logic        p, q;
    repeat (12) @(posedge lk);
    repeat (n) begin
      @(negedge lk);
      #20;
      for (int c = 0; c < 4; c++) begin
        src = (e_lp[c] == 1) ? hist[2] : hist[1];
        sh = (e_lp[c] == 0) ? 0 : 2;
        p = src[4*c+sh] & ~e_off[c];
        q = src[4*c+sh+1] & ~e_off[c];
        cmp({3'h0, rc[c], rn[c] | e_sr[c] & q, rp[c]}, {3'h0, e_inv[c] & ~e_off[c], q, p | e_sr[c] & q});
        cmp({4'h0, rn[c] & e_sr[c], ltp[c]}, {5'h00, hist[1][4*c+2]});
        cmp({5'h00, ltn[c]}, {5'h00, hist[1][4*c+3]});
      end
    end
    // Hand back just after a system edge, like every other drive
    @(posedge ref_clk);
    #1;
  endtask

  // Print the counts and the verdict, then stop
  task automatic tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {host, inv_pin, rail_pin, off_pin, wr, rd} = 6'h00;
    {ll_pin, rl_pin, chan, idx, wdata} = 18'h00000;
    {e_inv, e_sr, e_off} = 12'h000;
    e_lp = '{0, 0, 0, 0};
    fails = 0;
    n_compared = 0;
    repeat (2) @(posedge lk);
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int c = 0; c < 4; c++) begin
      reg_rd(c, `RXF_CR3_IDX, `RXF_CR3_RESET);
      reg_rd(c, `RXF_CR4_IDX, `RXF_CR4_RESET);
    end
    // Hardware default, dual rail, no loop
    check_rails(8);
    // Invert pin turns every clock round
    inv_pin = 1'b1;
    e_inv = 4'hF;
    check_rails(8);
    // Rail pin selects single rail for all
    rail_pin = 1'b1;
    e_sr = 4'hF;
    check_rails(8);
    off_pin = 1'b1;
    e_off = 4'hF;
    check_rails(6);
    {inv_pin, rail_pin, off_pin} = 3'h0;
    {e_inv, e_sr, e_off} = 12'h000;
    ll_pin = 4'h3;
    rl_pin = 4'h6;
    e_lp = '{1, 2, 0, 0};
    check_rails(8);
    // Host mode, pins ignored, registers per channel
    host = 1'b1;
    {inv_pin, rail_pin} = 2'h3;
    ll_pin = 4'hC;
    rl_pin = 4'h0;
    reg_wr(0, `RXF_CR3_IDX, 5'h02);
    reg_wr(0, `RXF_CR4_IDX, 5'h02);
    reg_wr(1, `RXF_CR3_IDX, 5'h10);
    reg_wr(1, `RXF_CR4_IDX, 5'h03);
    reg_wr(2, `RXF_CR3_IDX, 5'h04);
    reg_wr(3, `RXF_CR3_IDX, 5'h12);
    reg_wr(3, `RXF_CR4_IDX, 5'h01);
    e_inv = 4'h9;
    e_sr = 4'hA;
    e_off = 4'h4;
    check_rails(8);
    // Writing zero turns the receiver back on
    reg_wr(2, `RXF_CR3_IDX, 5'h00);
    e_off = 4'h0;
    check_rails(6);
    ce = 1'b0;
    reg_wr(0, `RXF_CR3_IDX, 5'h10);
    ce = 1'b1;
    reg_rd(0, `RXF_CR3_IDX, 5'h02);
    reg_rd(1, `RXF_CR4_IDX, 5'h03);
    reg_wr(3, `RXF_CR3_IDX, 5'h1F);
    reg_rd(3, `RXF_CR3_IDX, 5'h1F & `RXF_CR3_MASK);
    reg_wr(3, `RXF_CR4_IDX, 5'h1F);
    reg_rd(3, `RXF_CR4_IDX, 5'h1F & `RXF_CR4_MASK);
    reg_wr(1, 3'h7, 5'h1F);
    reg_rd(1, 3'h7, 5'h00);
    reg_rd(1, 3'h0, 5'h00);
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
